// ### src/hcr_consts.svh
// Offsets, field positions, masks and reset values of the hub configuration bank
`ifndef HCR_CONSTS_SVH
`define HCR_CONSTS_SVH

// ****************************************************************
// Register word indices (byte address is four times the index)
// ****************************************************************
`define HCR_IDX_TOPOLOGY_A 4'h0
`define HCR_IDX_TOPOLOGY_B 4'h1
`define HCR_IDX_POWER_GOOD_DELAY 4'h2
`define HCR_IDX_PRODUCT_ID_LOW 4'h3
`define HCR_IDX_PRODUCT_ID_HIGH 4'h4
`define HCR_IDX_VENDOR_ID_LOW 4'h5
`define HCR_IDX_VENDOR_ID_HIGH 4'h6
`define HCR_IDX_USB_CONTROL 4'h7
`define HCR_IDX_GLOBAL_CONTROL 4'h8
`define HCR_NUM_REGS 9
`define HCR_IDX_LSB 2
`define HCR_IDX_MSB 5

// ****************************************************************
// Field positions and write masks
// ****************************************************************
`define HCR_TOPO_B_PORT5_ENABLE 0
`define HCR_TOPO_B_PORT5_FIXED 1
`define HCR_TOPO_B_PORT6_LSB 4
`define HCR_TOPO_B_PORT6_MSB 5
`define HCR_TOPO_B_POWER_SWITCH 7
`define HCR_TOPO_B_WRITE_MASK 8'hb3
`define HCR_USB_CTL_GATE 4
`define HCR_USB_CTL_ATTACH 7
`define HCR_USB_CTL_WRITE_MASK 8'h90
`define HCR_GLOB_CTL_POLARITY 0
`define HCR_GLOB_CTL_WRITE_MASK 8'h01

// ****************************************************************
// Reset values
// ****************************************************************
`define HCR_REG_RESET 8'h00
`define HCR_SYNC_IDLE 1'b1
`define HCR_RESET_OUT_AT_RESET 1'b0

`endif

// ### src/hcr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
`include "hcr_consts.svh"

module hcr_pin_sync
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and filtered level
  input wire logic pin,
  output logic level
);

  logic s1;
  logic s2;
  logic s3;

  // A change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= `HCR_SYNC_IDLE;
      s2 <= `HCR_SYNC_IDLE;
      s3 <= `HCR_SYNC_IDLE;
      level <= `HCR_SYNC_IDLE;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
      begin
        level <= s3;
      end
    end
  end

endmodule
`default_nettype wire

// ### src/hcr_pkg.sv
// Types shared by the hub configuration bank
package hcr_pkg;

  // Embedded port six state
  typedef enum logic [1:0] {
    HCR_P6_ABSENT = 2'h0,
    HCR_P6_FIXED = 2'h1,
    HCR_P6_REMOVABLE_OUT = 2'h2,
    HCR_P6_REMOVABLE_IN = 2'h3
  } hcr_port6_state_t;

  // Configuration the hub core reads; index 0 is port one
  typedef struct packed {
    logic power_switching_available;
    hcr_port6_state_t port_six_embedded_state;
    logic [4:0] port_enable;
    logic [4:0] port_fixed;
    logic [7:0] power_good_delay;
    logic [15:0] product_id;
    logic [15:0] vendor_id;
  } hcr_hub_cfg_t;

endpackage

// ### src/hcr_top.sv
// Hub configuration bank with reset interconnect and pullup control
`timescale 1ns/1ns
`default_nettype none
`include "hcr_consts.svh"

//
// Overview of operation
// - Topology and power-good registers clear on power-up reset only.
// - Topology A even bits 0,2,4,6 enable ports one to four.
// - Topology A odd bits 1,3,5,7 mark ports one to four permanent.
// - Topology B bit 0 enables port five, bit 1 marks it permanent.
// - Topology B bits 5:4 give embedded port six state, reset 00b.
// - Topology B bit 7 reports power switching available, reset 0.
// - Power-good delay byte, units of 2 ms, reset 0.
// - Two read-write bytes hold hub product identifier.
// - Two read-write bytes hold hub vendor identifier.
// - Internal reset on power-up reset, or gated function reset.
// - Function reset gate bit is cleared at power-up.
// - Internal reset clears only the four identifier bytes; topology, power-good and control are kept.
// - Reset output carries internal reset, polarity chosen by global control.
// - Attach bit 1 drives pullup high, 0 drives it low.
// - Attach control is bit seven of the USB control register.
module hcr_top
#(
  parameter int ADDR_W = 12
)
(
  // Clock and power-up reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // USB function reset pin, active low
  input wire logic function_reset_in_n,
  // Reset and pullup pins
  output logic internal_reset_n,
  output logic reset_output_pin,
  output logic pullup_drive_pin,
  // Configuration to the hub core
  output hcr_pkg::hcr_hub_cfg_t hub_cfg
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic [3:0] addr_idx;
  wire logic addr_hit;
  wire logic access;
  wire logic next_pready;
  wire logic wr_en;
  wire logic [7:0] wr_byte;
  wire logic [`HCR_NUM_REGS-1:0] wr_sel;
  wire logic [7:0] reg_view [0:`HCR_NUM_REGS-1];
  wire logic [7:0] rd_byte;

  assign addr_idx = paddr[`HCR_IDX_MSB:`HCR_IDX_LSB];
  assign addr_hit = (paddr[ADDR_W-1:`HCR_IDX_MSB+1] == '0)
                  && (paddr[`HCR_IDX_LSB-1:0] == 2'h0)
                  && (addr_idx < 4'(`HCR_NUM_REGS));
  assign access = psel && penable;
  assign next_pready = access && !pready;
  // A write lands only at the edge where the master sees pready
  assign wr_en = access && pready && pwrite && addr_hit;
  assign wr_byte = pwdata[7:0];

  genvar gi;
  generate
    for (gi = 0; gi < `HCR_NUM_REGS; gi++)
    begin : g_sel
      assign wr_sel[gi] = wr_en && (addr_idx == 4'(gi));
    end
  endgenerate

  assign rd_byte = addr_hit ? reg_view[addr_idx] : 8'h00;

  // ****************************************************************
  // APB answer
  // ****************************************************************
  // One wait state keeps every bus output on a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= next_pready;
      prdata <= next_pready ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= next_pready && !addr_hit;
    end
  end

  // ****************************************************************
  // Function reset interconnect
  // ****************************************************************
  logic fr_level_n;
  logic [7:0] usb_control_reg;
  logic [7:0] global_control_reg;
  wire logic function_reset_gate;
  wire logic fr_clear;
  wire logic next_internal_reset_n;
  wire logic next_reset_output;

  hcr_pin_sync u_fr_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin(function_reset_in_n),
    .level(fr_level_n)
  );

  assign function_reset_gate = usb_control_reg[`HCR_USB_CTL_GATE];
  assign fr_clear = !fr_level_n && function_reset_gate;
  assign next_internal_reset_n = !fr_clear;
  // Polarity bit set gives an active-high reset pin
  assign next_reset_output = global_control_reg[`HCR_GLOB_CTL_POLARITY]
                           ? !next_internal_reset_n
                           : next_internal_reset_n;

  // ****************************************************************
  // Hub topology and power-good delay
  // ****************************************************************
  logic [7:0] hub_port_topology_a;
  logic [7:0] hub_port_topology_b;
  logic [7:0] hub_power_good_delay;

  // Function reset deliberately absent here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hub_port_topology_a <= `HCR_REG_RESET;
      hub_port_topology_b <= `HCR_REG_RESET;
      hub_power_good_delay <= `HCR_REG_RESET;
    end
    else
    begin
      if (wr_sel[`HCR_IDX_TOPOLOGY_A])
      begin
        hub_port_topology_a <= wr_byte;
      end
      if (wr_sel[`HCR_IDX_TOPOLOGY_B])
      begin
        hub_port_topology_b <= wr_byte & `HCR_TOPO_B_WRITE_MASK;
      end
      if (wr_sel[`HCR_IDX_POWER_GOOD_DELAY])
      begin
        hub_power_good_delay <= wr_byte;
      end
    end
  end

  // ****************************************************************
  // Product and vendor identifiers
  // ****************************************************************
  // Identifiers belong to ordinary logic, so a gated function reset clears them
  logic [7:0] id_byte [0:3];

  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_id
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          id_byte[gi] <= `HCR_REG_RESET;
        end
        else if (fr_clear)
        begin
          id_byte[gi] <= `HCR_REG_RESET;
        end
        else if (wr_sel[`HCR_IDX_PRODUCT_ID_LOW + gi])
        begin
          id_byte[gi] <= wr_byte;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // USB and global control
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usb_control_reg <= `HCR_REG_RESET;
      global_control_reg <= `HCR_REG_RESET;
    end
    else
    begin
      if (wr_sel[`HCR_IDX_USB_CONTROL])
      begin
        usb_control_reg <= wr_byte & `HCR_USB_CTL_WRITE_MASK;
      end
      if (wr_sel[`HCR_IDX_GLOBAL_CONTROL])
      begin
        global_control_reg <= wr_byte & `HCR_GLOB_CTL_WRITE_MASK;
      end
    end
  end

  // ****************************************************************
  // Read view
  // ****************************************************************
  assign reg_view[`HCR_IDX_TOPOLOGY_A] = hub_port_topology_a;
  assign reg_view[`HCR_IDX_TOPOLOGY_B] = hub_port_topology_b;
  assign reg_view[`HCR_IDX_POWER_GOOD_DELAY] = hub_power_good_delay;
  assign reg_view[`HCR_IDX_PRODUCT_ID_LOW] = id_byte[0];
  assign reg_view[`HCR_IDX_PRODUCT_ID_HIGH] = id_byte[1];
  assign reg_view[`HCR_IDX_VENDOR_ID_LOW] = id_byte[2];
  assign reg_view[`HCR_IDX_VENDOR_ID_HIGH] = id_byte[3];
  assign reg_view[`HCR_IDX_USB_CONTROL] = usb_control_reg;
  assign reg_view[`HCR_IDX_GLOBAL_CONTROL] = global_control_reg;

  // ****************************************************************
  // Pins
  // ****************************************************************
  // Pullup follows the attach bit; toggling it re-enumerates without a replug
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      internal_reset_n <= 1'b0;
      reset_output_pin <= `HCR_RESET_OUT_AT_RESET;
      pullup_drive_pin <= 1'b0;
    end
    else
    begin
      internal_reset_n <= next_internal_reset_n;
      reset_output_pin <= next_reset_output;
      pullup_drive_pin <= usb_control_reg[`HCR_USB_CTL_ATTACH];
    end
  end

  // ****************************************************************
  // Hub core configuration
  // ****************************************************************
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_port
      assign hub_cfg.port_enable[gi] = hub_port_topology_a[2*gi];
      assign hub_cfg.port_fixed[gi] = hub_port_topology_a[2*gi+1];
    end
  endgenerate

  assign hub_cfg.port_enable[4] = hub_port_topology_b[`HCR_TOPO_B_PORT5_ENABLE];
  assign hub_cfg.port_fixed[4] = hub_port_topology_b[`HCR_TOPO_B_PORT5_FIXED];
  assign hub_cfg.port_six_embedded_state = hcr_pkg::hcr_port6_state_t'(
    hub_port_topology_b[`HCR_TOPO_B_PORT6_MSB:`HCR_TOPO_B_PORT6_LSB]);
  assign hub_cfg.power_switching_available = hub_port_topology_b[`HCR_TOPO_B_POWER_SWITCH];
  assign hub_cfg.power_good_delay = hub_power_good_delay;
  assign hub_cfg.product_id = {id_byte[1], id_byte[0]};
  assign hub_cfg.vendor_id = {id_byte[3], id_byte[2]};

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_topo_a_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_sel[`HCR_IDX_TOPOLOGY_A] |=> hub_port_topology_a == $past(pwdata[7:0]))
    else $error("topology A did not take the written byte");

  chk_topo_keep_fr: assert property (
    @(posedge pclk) disable iff (!presetn)
    (fr_clear && !wr_en) |=> $stable(hub_port_topology_a) && $stable(hub_power_good_delay)
      && $stable(hub_port_topology_b))
    else $error("function reset disturbed hub configuration");

  chk_topo_b_rsv: assert property (
    @(posedge pclk) disable iff (!presetn)
    hub_port_topology_b[3:2] == 2'h0 && hub_port_topology_b[6] == 1'b0)
    else $error("reserved topology B bits not zero");

  chk_pgd_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_sel[`HCR_IDX_POWER_GOOD_DELAY] |=> hub_cfg.power_good_delay == $past(pwdata[7:0]))
    else $error("power-good delay not written");

  chk_int_reset: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> internal_reset_n == !$past(!fr_level_n && usb_control_reg[`HCR_USB_CTL_GATE]))
    else $error("internal reset does not follow gated function reset");

  chk_id_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    fr_clear |=> hub_cfg.product_id == 16'h0000 && hub_cfg.vendor_id == 16'h0000)
    else $error("identifiers survived function reset");

  chk_ctl_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    (fr_clear && !wr_en) |=> $stable(usb_control_reg) && $stable(global_control_reg))
    else $error("control registers disturbed by function reset");

  chk_rst_out_pol: assert property (
    @(posedge pclk) disable iff (!presetn)
    reset_output_pin == ($past(global_control_reg[0]) ? !internal_reset_n : internal_reset_n))
    else $error("reset output polarity wrong");

  chk_attach_pullup: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_sel[`HCR_IDX_USB_CONTROL] |=> ##1 pullup_drive_pin == $past(pwdata[7], 2))
    else $error("pullup does not follow attach bit");

  chk_id_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_sel[`HCR_IDX_PRODUCT_ID_HIGH] && !fr_clear) |=> hub_cfg.product_id[15:8] == $past(pwdata[7:0]))
    else $error("product identifier high byte not written");

  chk_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held longer than one cycle");

  chk_unmapped_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    next_pready && !addr_hit |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

endmodule
`default_nettype wire

// ### tb/hcr_usb_upstream.sv
// Upstream port model: drives the bus reset pin and counts attaches
`timescale 1ns/1ns
`default_nettype none

module hcr_usb_upstream
(
  // Clock
  input wire logic pclk,
  // Pins of the bank
  input wire logic pullup_drive_pin,
  output logic function_reset_in_n,
  // Bench control and status
  input wire logic bus_reset_req,
  output logic [7:0] connect_cnt
);
  logic seen = 1'b0;
  logic [7:0] cnt = 8'h00;

  // ****************************************************************
  // Bus reset and attach watch
  // ****************************************************************
  // The pin is asynchronous to the bank, so a plain level is enough
  assign function_reset_in_n = !bus_reset_req;

  assign connect_cnt = cnt;

  // Each rising pullup is a fresh attach that starts enumeration
  always @(posedge pclk)
  begin
    if (pullup_drive_pin === 1'b1 && seen !== 1'b1)
      cnt <= cnt + 8'h01;
    seen <= pullup_drive_pin;
  end
endmodule
`default_nettype wire

// ### tb/tb_hcr_top.sv
// Self-checking bench for the hub configuration bank
`timescale 1ns/1ns
`default_nettype none
`include "hcr_consts.svh"

module tb_hcr_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_reset_req;
  logic function_reset_in_n, internal_reset_n, reset_output_pin, pullup_drive_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [7:0] connect_cnt;
  logic [7:0] shadow [0:6];
  logic [8:0] note_q [$];
  logic [8:0] note;
  hcr_pkg::hcr_hub_cfg_t hub_cfg;
  int error_cnt, compares;

  hcr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .function_reset_in_n(function_reset_in_n), .internal_reset_n(internal_reset_n),
    .reset_output_pin(reset_output_pin), .pullup_drive_pin(pullup_drive_pin), .hub_cfg(hub_cfg));

  hcr_usb_upstream far_side (.pclk(pclk), .pullup_drive_pin(pullup_drive_pin),
    .function_reset_in_n(function_reset_in_n), .bus_reset_req(bus_reset_req), .connect_cnt(connect_cnt));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] ad(input logic [3:0] idx);
    return {6'h00, idx, 2'h0};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Exp carries {slave error, read byte}; a write answers with the byte held before it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [8:0] exp);
    int n;
    note_q.push_back(exp);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Hold the request until pready is seen high at a rising edge
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      $display("FAIL %0t no bus answer", $time);
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    for (n = 0; n < 40 && s !== v; n++)
      @(negedge pclk);
    if (s !== v)
    begin
      error_cnt++;
      $display("FAIL %0t level wait timed out", $time);
      close_out();
    end
  endtask

  task automatic reset_check();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++)
      apb(1'b0, ad(i[3:0]), 8'h00, 9'h000);
    chk(64'(hub_cfg), 64'h0);
    chk(64'({reset_output_pin, pullup_drive_pin}), 64'h2);
  endtask

  // Oldest note is compared whenever the slave answers
  always @(negedge pclk)
    if (pready === 1'b1)
    begin
      note = (note_q.size() > 0) ? note_q.pop_front() : 9'h1ff;
      chk(64'({pslverr, prdata}), 64'({note[8], 24'h000000, note[7:0]}));
    end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    bus_reset_req = 1'b0;
    error_cnt = 0;
    compares = 0;
    seed = 32'h19cf9348;
    reset_check();
    apb(1'b0, ad(4'h9), 8'h00, 9'h100);
    apb(1'b0, 12'h005, 8'h00, 9'h100);
    apb(1'b1, ad(4'h9), 8'h5a, 9'h100);
    for (int i = 0; i < 7; i++)
    begin
      seed = lfsr(seed);
      shadow[i] = (i == 1) ? (seed[7:0] & `HCR_TOPO_B_WRITE_MASK) : seed[7:0];
      apb(1'b1, ad(i[3:0]), seed[7:0], 9'h000);
    end
    for (int i = 0; i < 7; i++)
      apb(1'b0, ad(i[3:0]), 8'h00, {1'b0, shadow[i]});
    chk(64'(hub_cfg.port_enable), 64'({shadow[1][0], shadow[0][6], shadow[0][4], shadow[0][2], shadow[0][0]}));
    chk(64'(hub_cfg.port_fixed), 64'({shadow[1][1], shadow[0][7], shadow[0][5], shadow[0][3], shadow[0][1]}));
    chk(64'({hub_cfg.power_switching_available, hub_cfg.power_good_delay}), 64'({shadow[1][7], shadow[2]}));
    chk(64'({hub_cfg.product_id, hub_cfg.vendor_id}), 64'({shadow[4], shadow[3], shadow[6], shadow[5]}));
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, ad(`HCR_IDX_TOPOLOGY_B), {2'h3, m[1:0], 4'hf}, {1'b0, (m == 0) ? shadow[1] : {2'h2, m[1:0] - 2'h1, 4'h3}});
      @(negedge pclk);
      chk(64'(hub_cfg.port_six_embedded_state), 64'(m[1:0]));
      apb(1'b0, ad(`HCR_IDX_TOPOLOGY_B), 8'h00, {3'h2, m[1:0], 4'h3});
    end
    shadow[1] = 8'hb3;
    // Attach, detach and attach again forces a second enumeration
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, ad(`HCR_IDX_USB_CONTROL), (k == 1) ? 8'h00 : 8'h80, {1'b0, (k == 1) ? 8'h80 : 8'h00});
      repeat (2) @(negedge pclk);
      chk(64'(pullup_drive_pin), 64'(k != 1));
    end
    // The far side counts one edge after it sees the pin rise
    @(negedge pclk);
    chk(64'(connect_cnt), 64'h2);
    // Function reset is ignored while its gate is clear
    @(posedge pclk);
    bus_reset_req <= 1'b1;
    repeat (12) @(posedge pclk);
    chk(64'(internal_reset_n), 64'h1);
    bus_reset_req <= 1'b0;
    // Let the released pin clear the synchroniser before the gate opens
    repeat (4) @(posedge pclk);
    apb(1'b1, ad(`HCR_IDX_USB_CONTROL), 8'h90, 9'h080);
    bus_reset_req <= 1'b1;
    wait_lvl(internal_reset_n, 1'b0);
    repeat (2) @(negedge pclk);
    chk(64'(reset_output_pin), 64'h0);
    @(posedge pclk);
    bus_reset_req <= 1'b0;
    wait_lvl(internal_reset_n, 1'b1);
    for (int i = 0; i < 7; i++)
      apb(1'b0, ad(i[3:0]), 8'h00, {1'b0, (i < 3) ? shadow[i] : 8'h00});
    apb(1'b0, ad(`HCR_IDX_USB_CONTROL), 8'h00, 9'h090);
    // Active-high polarity leaves the output low while no reset is seen
    apb(1'b1, ad(`HCR_IDX_GLOBAL_CONTROL), 8'h01, 9'h000);
    repeat (2) @(negedge pclk);
    chk(64'(reset_output_pin), 64'h0);
    @(posedge pclk);
    bus_reset_req <= 1'b1;
    wait_lvl(internal_reset_n, 1'b0);
    repeat (2) @(negedge pclk);
    chk(64'(reset_output_pin), 64'h1);
    @(posedge pclk);
    bus_reset_req <= 1'b0;
    wait_lvl(internal_reset_n, 1'b1);
    apb(1'b0, ad(`HCR_IDX_GLOBAL_CONTROL), 8'h00, 9'h001);
    reset_check();
    close_out();
  end
endmodule
`default_nettype wire
